/* File: include/sar_adc_defines.svh */
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// result word
`define CODE_W          14
`define LOWEST_CODE     14'h0000
`define MIDSCALE_CODE   14'h1fff
`define HIGHEST_CODE    14'h3fff
// shifted out after a frame that ended before conversion finished
`define INVALID_CODE    14'h2aaa
// power-up result shifted out in the very first frame
`define RESET_CODE      14'h0000

// falling serial clock edges per frame
`define CNT_W           7
`define CONV_EDGES      7'h12
`define PWRUP_CAL_EDGES 7'h18
`define RUN_CAL_EDGES   7'h40
`define CNT_MAX         7'h7f

`endif

/* File: include/sar_adc_pkg.sv */
package sar_adc_pkg;

  typedef enum logic [1:0] {
    sample_track_state,
    convert_state,
    offset_trim_state
  } state_t;

  typedef struct packed {
    logic [13:0] code;
    logic        valid;
  } result_t;

  typedef struct packed {
    state_t state;
    logic   trimActive;
    logic   trimDone;
    logic   firstFrame;
  } status_t;

endpackage : sar_adc_pkg

/* File: hw/sar_adc_serial_frame_control.sv */
`timescale 1ns/1ps
`include "sar_adc_defines.svh"

// sample buffer between the digitised input and the converter core
module sar_adc_sample_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  wire              empty = (wrPtr_q == rdPtr_q);
  wire              full  = (wrPtr_q[AW] != rdPtr_q[AW]) &&
                            (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  wire              push  = inValid && !full;
  wire              pop   = outReady && !empty;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + (AW+1)'(push);
      rdPtr_q <= rdPtr_q + (AW+1)'(pop);
    end
  end

endmodule : sar_adc_sample_fifo

// Summary of operation
// - result is fourteen bits per sample
// - codes are unsigned straight binary, 0000..3fff
// - sample on chip select fall, clock converts
// - start in sample track state
// - chip select fall opens, rise closes frame
// - serial output released while chip select high
// - serial clock times conversion and data out
// - only three states, chosen by host pins
// - back to tracking after conversion or trim
// - chip select fall while tracking starts conversion
// - under eighteen falls gives invalid next result
// - leading zero, fourteen bits msb first, zeros
// - first frame twenty-four clocks trims offset
// - sixty-four clocks trims offset in normal frames
module sar_adc_serial_frame_control #(
  parameter int CODE_W     = `CODE_W,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // serial pins
  input  wire logic                    csN,
  input  wire logic                    sclk,
  output logic                         sdoOut,
  output logic                         sdoOe,
  // digitised input samples
  input  wire logic                    sampleValid,
  output logic                         sampleReady,
  input  wire logic [CODE_W-1:0]       sampleCode,
  // results and state
  output sar_adc_pkg::result_t         resultOut,
  output sar_adc_pkg::status_t         statusOut
);

  // pin synchronisers; stage one feeds only stage two
  logic csMeta_q;
  logic csSync_q;
  logic csPrev_q;
  logic sclkMeta_q;
  logic sclkSync_q;
  logic sclkPrev_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      csMeta_q   <= 1'b1;
      csSync_q   <= 1'b1;
      csPrev_q   <= 1'b1;
      // idle level of the serial clock, so no false edge after reset
      sclkMeta_q <= 1'b1;
      sclkSync_q <= 1'b1;
      sclkPrev_q <= 1'b1;
    end else begin
      csMeta_q   <= csN;
      csSync_q   <= csMeta_q;
      csPrev_q   <= csSync_q;
      sclkMeta_q <= sclk;
      sclkSync_q <= sclkMeta_q;
      sclkPrev_q <= sclkSync_q;
    end
  end

  wire csFall   = csPrev_q && !csSync_q;
  wire csRise   = !csPrev_q && csSync_q;
  wire inFrame  = !csSync_q;
  // clock edges only count inside a frame
  wire sclkFall = sclkPrev_q && !sclkSync_q && inFrame;
  wire sclkRise = !sclkPrev_q && sclkSync_q && inFrame;

  sar_adc_pkg::state_t     state_q;
  sar_adc_pkg::state_t     state_d;
  logic [`CNT_W-1:0]       fallCount_q;
  logic                    firstFrame_q;
  logic                    convDone_q;
  logic [CODE_W-1:0]       heldCode_q;
  logic [CODE_W-1:0]       pending_q;
  logic [CODE_W-1:0]       prevCode_q;
  logic [CODE_W-1:0]       shift_q;
  logic                    seenFall_q;
  logic                    sdo_q;
  logic                    sdoOe_q;
  logic                    trimDone_q;
  sar_adc_pkg::result_t    result_q;

  // sample buffer; it drains only when a frame opens in tracking,
  // so a slow host really fills it and stalls the source
  logic                    fifoValid;
  logic [CODE_W-1:0]       fifoData;
  wire                     isTrack = (state_q ==
                                      sar_adc_pkg::sample_track_state);
  wire                     isConv  = (state_q ==
                                      sar_adc_pkg::convert_state);
  wire                     isTrim  = (state_q ==
                                      sar_adc_pkg::offset_trim_state);
  wire                     takeSample = csFall && isTrack;

  sar_adc_sample_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (sys_clk),
    .rst      (rst),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .inData   (sampleCode),
    .outValid (fifoValid),
    .outReady (takeSample),
    .outData  (fifoData)
  );

  // decode of edge counts
  wire [`CNT_W-1:0] calTarget = firstFrame_q ? `PWRUP_CAL_EDGES
                                             : `RUN_CAL_EDGES;
  wire convLast   = sclkFall && isConv &&
                    (fallCount_q == `CONV_EDGES - `CNT_W'(1));
  wire trimEnter  = sclkFall && isTrack && (fallCount_q == `CONV_EDGES);
  wire trimLast   = sclkFall && isTrim &&
                    (fallCount_q == calTarget - `CNT_W'(1));
  // frame closed before the conversion finished
  wire shortFrame = csRise && !convDone_q && !convLast;
  wire [CODE_W-1:0] nextPrev = (convDone_q || convLast) ? pending_q
                                                        : `INVALID_CODE;

  // three states, moved only by pin activity
  always_comb begin
    state_d = state_q;
    case (state_q)
      sar_adc_pkg::sample_track_state: begin
        if (csFall) begin
          state_d = sar_adc_pkg::convert_state;
        end else if (trimEnter && !csRise) begin
          state_d = sar_adc_pkg::offset_trim_state;
        end
      end
      sar_adc_pkg::convert_state: begin
        // back to tracking when done or cut short
        if (csRise || convLast) begin
          state_d = sar_adc_pkg::sample_track_state;
        end
      end
      sar_adc_pkg::offset_trim_state: begin
        // early close aborts, full count completes
        if (csRise || trimLast) begin
          state_d = sar_adc_pkg::sample_track_state;
        end
      end
      default: begin
        state_d = sar_adc_pkg::sample_track_state;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= sar_adc_pkg::sample_track_state;
    end else begin
      state_q <= state_d;
    end
  end

  // count falls, restart at frame open
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fallCount_q <= '0;
    end else if (csFall) begin
      fallCount_q <= '0;
    end else if (sclkFall && fallCount_q != `CNT_MAX) begin
      fallCount_q <= fallCount_q + `CNT_W'(1);
    end
  end

  // capture the input as the frame opens
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      heldCode_q <= `LOWEST_CODE;
    end else if (takeSample && fifoValid) begin
      heldCode_q <= fifoData;
    end
  end

  // the straight binary word passes through unaltered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending_q  <= `LOWEST_CODE;
      convDone_q <= 1'b0;
    end else if (csFall) begin
      convDone_q <= 1'b0;
    end else if (convLast) begin
      pending_q  <= heldCode_q;
      convDone_q <= 1'b1;
    end
  end

  // judge the frame at its close
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prevCode_q   <= `RESET_CODE;
      firstFrame_q <= 1'b1;
      result_q     <= '0;
    end else begin
      result_q.valid <= csRise && !shortFrame;
      if (csRise) begin
        prevCode_q    <= nextPrev;
        firstFrame_q  <= 1'b0;
        result_q.code <= nextPrev;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trimDone_q <= 1'b0;
    end else begin
      trimDone_q <= trimLast && !csRise;
    end
  end

  // leading zero, then msb first on rises after a fall
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_q    <= '0;
      seenFall_q <= 1'b0;
      sdo_q      <= 1'b0;
    end else if (csFall) begin
      shift_q    <= prevCode_q;
      seenFall_q <= 1'b0;
      sdo_q      <= 1'b0;
    end else begin
      if (sclkFall) begin
        seenFall_q <= 1'b1;
      end
      if (sclkRise && seenFall_q) begin
        sdo_q   <= shift_q[CODE_W-1];
        shift_q <= {shift_q[CODE_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sdoOe_q <= 1'b0;
    end else begin
      sdoOe_q <= inFrame;
    end
  end

  assign sdoOut               = sdo_q;
  assign sdoOe                = sdoOe_q;
  assign resultOut            = result_q;
  assign statusOut            = '{state:      state_q,
                                  trimActive: isTrim,
                                  trimDone:   trimDone_q,
                                  firstFrame: firstFrame_q};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence frameOpen;
    csFall && isTrack;
  endsequence

  sequence shiftStep;
    sclkRise && seenFall_q && !csFall;
  endsequence

  sequence frameClose;
    csRise;
  endsequence

  reset_tracks_a: assert property (
    $past(rst) |-> isTrack)
    else $error("not tracking after reset");

  legal_state_a: assert property (
    isTrack || isConv || isTrim)
    else $error("illegal state code");

  open_converts_a: assert property (
    frameOpen |=> isConv && fallCount_q == '0)
    else $error("frame open did not start conversion");

  lead_zero_a: assert property (
    csFall |-> !sdoOe_q ##1 (sdoOe_q && !sdo_q))
    else $error("leading zero missing");

  shift_msb_a: assert property (
    shiftStep |=> sdo_q == $past(shift_q[CODE_W-1]))
    else $error("serial bit out of order");

  release_out_a: assert property (
    frameClose |=> !sdoOe ##1 !sdoOe)
    else $error("output driven after frame close");

  short_invalid_a: assert property (
    frameClose ##0 shortFrame |=> prevCode_q == `INVALID_CODE
      && !resultOut.valid)
    else $error("short frame not marked invalid");

  sample_taken_a: assert property (
    frameOpen ##0 fifoValid |=> heldCode_q == $past(fifoData))
    else $error("sample not captured at frame open");

  conv_result_a: assert property (
    convLast |=> convDone_q && pending_q == $past(heldCode_q))
    else $error("conversion result not latched");

  trim_return_a: assert property (
    trimDone_q |-> isTrack && $past(isTrim))
    else $error("trim end not back in tracking");

  trim_abort_a: assert property (
    isTrim && csRise |=> isTrack && !trimDone_q)
    else $error("aborted trim not handled");

endmodule : sar_adc_serial_frame_control

/* File: tb/sar_adc_host_model.sv */
`timescale 1ns/1ps
module sar_adc_host_model (
  // clock
  input  wire logic                 sys_clk,
  // serial pins
  output logic                      csN,
  output logic                      sclk,
  input  wire logic                 sdoOut,
  input  wire logic                 sdoOe,
  // observed state
  input  wire sar_adc_pkg::status_t statusOut
);
  logic [63:0]          bitsQ;
  logic                 oeAll;
  logic                 sdoLast;
  logic                 sdoLine;
  sar_adc_pkg::status_t stAt1;
  sar_adc_pkg::status_t stAt19;

  // released line floats
  // no pull on the pin, so a stale level must not read as data
  assign sdoLine = sdoOe ? sdoOut : ~sdoLast;
  always @(posedge sys_clk) if (sdoOe === 1'b1) sdoLast <= sdoOut;

  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    sdoLast = 1'b0;
  end

  task automatic waitHalf(input int h);
    repeat (h) @(negedge sys_clk);
  endtask : waitHalf

  task automatic idleClocks(input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      waitHalf(6);
      sclk = 1'b1;
      waitHalf(6);
    end
  endtask : idleClocks

  task automatic frame(input int n, input int h);
    bitsQ = '0;
    oeAll = 1'b1;
    csN = 1'b0;
    waitHalf(h);
    for (int i = 0; i < n; i++) begin
      bitsQ[i] = sdoLine;
      oeAll = oeAll & sdoOe;
      sclk = 1'b0;
      waitHalf(h);
      if (i == 0) stAt1 = statusOut;
      if (i == 18) stAt19 = statusOut;
      sclk = 1'b1;
      waitHalf(h);
    end
    csN = 1'b1;
    waitHalf(6);
  endtask : frame
endmodule : sar_adc_host_model

/* File: tb/sar_adc_serial_frame_control_tb.sv */
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
module sar_adc_serial_frame_control_tb;
  typedef struct {
    logic [13:0] code;
    int          n;
    logic [13:0] shiftExp;
    logic        trim;
  } row_t;

  logic                 sys_clk;
  logic                 rst;
  logic                 csN;
  logic                 sclk;
  logic                 sdoOut;
  logic                 sdoOe;
  logic                 sampleValid;
  logic                 sampleReady;
  logic [13:0]          sampleCode;
  sar_adc_pkg::result_t resultOut;
  sar_adc_pkg::status_t statusOut;
  int                   err_total;
  int                   n_compared;
  int                   validCnt;
  int                   trimCnt;
  logic [13:0]          prev;
  row_t                 rows [8];

  sar_adc_serial_frame_control u_sar_adc_serial_frame_control (
    .sys_clk(sys_clk), .rst(rst), .csN(csN), .sclk(sclk),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleCode(sampleCode),
    .resultOut(resultOut), .statusOut(statusOut)
  );

  sar_adc_host_model u_sar_adc_host_model (
    .sys_clk(sys_clk), .csN(csN), .sclk(sclk), .sdoOut(sdoOut),
    .sdoOe(sdoOe), .statusOut(statusOut)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (resultOut.valid === 1'b1) validCnt++;
    if (statusOut.trimDone === 1'b1) trimCnt++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: %s seen %0h expected %0h",
               $time, what, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic push(input logic [13:0] c, input logic take);
    @(negedge sys_clk);
    sampleValid = 1'b1;
    sampleCode = c;
    check(sampleReady, take, "sample ready");
    @(negedge sys_clk);
    sampleValid = 1'b0;
  endtask : push

  task automatic runFrame(input int n, input int h, input logic [13:0] sh,
                          input logic trimExp, input logic [13:0] code);
    logic [63:0] expBits;
    logic [63:0] mask;
    expBits = '0;
    for (int k = 0; k < 14; k++) expBits[1+k] = sh[13-k];
    mask = (n == 64) ? '1 : ((64'h1 << n) - 64'h1);
    validCnt = 0;
    trimCnt = 0;
    u_sar_adc_host_model.frame(n, h);
    check(u_sar_adc_host_model.bitsQ & mask, expBits & mask, "bits");
    check(u_sar_adc_host_model.oeAll, 1'b1, "oe in frame");
    check(sdoOe, 1'b0, "oe after frame");
    check(u_sar_adc_host_model.stAt1.state, sar_adc_pkg::convert_state,
          "state fall 1");
    if (n >= 19) check(u_sar_adc_host_model.stAt19.state,
                       sar_adc_pkg::offset_trim_state, "trim");
    if (n >= 19) check(u_sar_adc_host_model.stAt19.trimActive, 1'b1,
                       "trim active");
    check(statusOut.trimActive, 1'b0, "trim idle at end");
    check(statusOut.state, sar_adc_pkg::sample_track_state, "end");
    check(validCnt, n >= `CONV_EDGES, "valid pulses");
    check(resultOut.code, code, "result code");
    check(trimCnt, trimExp, "trim done");
    check(statusOut.firstFrame, 1'b0, "first frame flag");
    $display("frame of %0d clocks done", n);
  endtask : runFrame

  task automatic resetCheck();
    rst = 1'b1;
    repeat (6) @(negedge sys_clk);
    check(sdoOe, 1'b0, "oe in reset");
    check(statusOut.state, sar_adc_pkg::sample_track_state, "rst st");
    check(statusOut.firstFrame, 1'b1, "first frame in reset");
    check(sampleReady, 1'b1, "ready in reset");
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    $display("reset test done");
  endtask : resetCheck

  initial begin
    repeat (50000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    sampleValid = 1'b0;
    sampleCode = 14'h0000;
    err_total = 0;
    n_compared = 0;
    rows = '{'{14'h3fff, 24, 14'h0000, 1'b1}, '{14'h0000, 18, 14'h3fff, 1'b0},
             '{14'h1fff, 18, 14'h0000, 1'b0}, '{14'h2000, 64, 14'h1fff, 1'b1},
             '{14'h1234, 10, 14'h2000, 1'b0}, '{14'h0abc, 18, 14'h2aaa, 1'b0},
             '{14'h0001, 30, 14'h0abc, 1'b0}, '{14'h1555, 18, 14'h0001, 1'b0}};
    resetCheck();
    u_sar_adc_host_model.idleClocks(3);
    check(sdoOe, 1'b0, "oe idle clocks");
    check(statusOut.firstFrame, 1'b1, "idle clocks ignored");
    foreach (rows[i]) begin
      push(rows[i].code, 1'b1);
      runFrame(rows[i].n, 6, rows[i].shiftExp, rows[i].trim,
               rows[i].n >= 18 ? rows[i].code : `INVALID_CODE);
    end
    for (int k = 1; k <= 4; k++) push(14'h0111 * k, 1'b1);
    push(14'h0555, 1'b0);
    prev = 14'h1555;
    // full buffer drains a word per frame; empty at last open reuses it
    for (int k = 1; k <= 5; k++) begin
      runFrame(18, 6, prev, 1'b0, 14'h0111 * (k < 5 ? k : 4));
      prev = 14'h0111 * (k < 5 ? k : 4);
    end
    resetCheck();
    push(14'h0ace, 1'b1);
    // first frame after reset cut before the trim completes
    runFrame(20, 6, `RESET_CODE, 1'b0, 14'h0ace);
    give_verdict();
  end
endmodule : sar_adc_serial_frame_control_tb
